//--- shared/usb_status_cfg.svh
`ifndef USB_STATUS_CFG_SVH
`define USB_STATUS_CFG_SVH

// Command code shared by the set and get forms of the status register
`define CMD_DEVICE_STATUS 8'hfe

// Field positions in the status byte
`define STAT_ATTACH_BIT 0
`define STAT_ATTACH_CHG_BIT 1
`define STAT_SLEEP_BIT 2
`define STAT_SLEEP_CHG_BIT 3
`define STAT_BUS_RESET_BIT 4

// Reset value of the status byte
`define STAT_RESET_VALUE 8'h00

// Timing
`define CLK_MHZ 40
`define IDLE_TIME_US 3000
`define IDLE_CYCLES (`IDLE_TIME_US * `CLK_MHZ)
`define WAKE_TIME_US 2000
`define WAKE_CYCLES (`WAKE_TIME_US * `CLK_MHZ)

// Physical endpoints held by the engine, two of them the control pipe
`define NUM_ENDPOINTS 32
`define CONTROL_EP_MASK 2'b11

`endif

//--- shared/usb_status_pkg.sv
package usb_status_pkg;

    // Processor command port toward the protocol engine
    typedef struct packed {
        logic cmd_strobe;
        logic [7:0] cmd_code;
        logic wr_strobe;
        logic [7:0] wr_data;
        logic rd_strobe;
    } cmd_port_t;

    // Bus condition levels from the line receiver and decoder
    typedef struct packed {
        logic vbus_present;
        logic bus_activity;
        logic bus_reset;
    } bus_events_t;

    // One-cycle orders to the rest of the engine on a bus reset
    typedef struct packed {
        logic unconfigure;
        logic address_zero;
        logic stall_control;
        logic unrealize;
        logic toggle_reset;
        logic flush_buffers;
        logic ep_irq_clear;
    } default_action_t;

    // Status byte as software sees it
    typedef struct packed {
        logic [2:0] reserved;
        logic bus_reset_flag;
        logic sleep_change_flag;
        logic sleep_flag;
        logic attach_change_flag;
        logic attach_state;
    } status_byte_t;

    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_ARMED = 2'b01
    } cmd_phase_t;

    typedef struct packed {
        cmd_phase_t phase;
        status_byte_t status;
        logic irq;
        logic [7:0] rdata;
        logic rdata_valid;
        logic vbus_q;
        logic reset_q;
        logic wake_start;
        default_action_t action;
    } core_state_t;

endpackage

//--- rtl/idle_timer.sv
`timescale 1ns/1ps
module idle_timer #(
    parameter int LIMIT = 120000
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic clear,
    output logic expired
);
    localparam int W = $clog2(LIMIT + 2);
    localparam logic [W-1:0] TOP = W'(LIMIT);

    typedef struct packed {
        logic [W-1:0] count;
        logic expired;
    } idle_state_t;

    idle_state_t st;
    idle_state_t next_st;

    // Expiry only after strictly more than the idle limit
    always_comb begin
        next_st = st;
        next_st.expired = 1'b0;
        if (clear || !run) begin
            next_st.count = '0;
        end else if (st.count == TOP) begin
            next_st.expired = 1'b1;
            next_st.count = '0;
        end else begin
            next_st.count = st.count + W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.expired;
endmodule

//--- rtl/wakeup_timer.sv
`timescale 1ns/1ps
module wakeup_timer #(
    parameter int LENGTH = 80000
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    output logic drive
);
    localparam int W = $clog2(LENGTH + 1);

    typedef struct packed {
        logic [W-1:0] left;
        logic drive;
    } wake_state_t;

    wake_state_t st;
    wake_state_t next_st;

    // A second start while driving is ignored, no stretched resume
    always_comb begin
        next_st = st;
        if (!st.drive && start) begin
            next_st.left = W'(LENGTH - 1);
            next_st.drive = 1'b1;
        end else if (st.drive) begin
            if (st.left == '0) begin
                next_st.drive = 1'b0;
            end else begin
                next_st.left = st.left - W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign drive = st.drive;
endmodule

//--- rtl/usb_device_status_flags.sv
`timescale 1ns/1ps
`include "usb_status_cfg.svh"
module usb_device_status_flags #(
    parameter int IDLE_CYCLES = `IDLE_CYCLES,
    parameter int WAKE_CYCLES = `WAKE_CYCLES,
    parameter int NUM_EP = `NUM_ENDPOINTS
) (
    input wire logic core_clk,
    input wire logic reset,
    input usb_status_pkg::cmd_port_t cmd,
    input usb_status_pkg::bus_events_t bus,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic pullup_enable_n,
    output logic status_event_irq,
    output logic remote_wakeup,
    output usb_status_pkg::default_action_t default_action,
    output logic [NUM_EP-1:0] unrealize_mask,
    output logic [NUM_EP-1:0] toggle_reset_mask
);

    ////////////////////////////////////////////////////////////////////////
    // State and event wires

    usb_status_pkg::core_state_t st;
    usb_status_pkg::core_state_t next_st;

    logic idle_expired;
    logic timer_run;
    logic timer_clear;
    logic status_write;
    logic status_read;
    logic vbus_lost;
    logic reset_rise;
    logic detach_event;
    logic next_sleep;
    logic sleep_toggle;
    logic next_attach;

    localparam logic [NUM_EP-1:0] CTRL_MASK =
        NUM_EP'(`CONTROL_EP_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    // Data phase only counts once the status command has armed it
    // status data phase
    assign status_write = (st.phase == usb_status_pkg::PHASE_ARMED) &&
                          !cmd.cmd_strobe && cmd.wr_strobe;

    // A read in the same cycle as a write is dropped, write wins
    // status read decode
    assign status_read = (st.phase == usb_status_pkg::PHASE_ARMED) &&
                         !cmd.cmd_strobe && !cmd.wr_strobe &&
                         cmd.rd_strobe;

    ////////////////////////////////////////////////////////////////////////
    // Bus events

    // Power loss only matters while the pull-up is applied
    // power loss detect
    assign vbus_lost = st.vbus_q && !bus.vbus_present &&
                       st.status.attach_state;

    assign reset_rise = bus.bus_reset && !st.reset_q;

    // Software detach counts the same as a power drop for sleep
    assign detach_event = st.status.attach_state &&
                          (vbus_lost ||
                           (status_write &&
                            !cmd.wr_data[`STAT_ATTACH_BIT]));

    // Idle time is only counted while attached and awake
    assign timer_run = st.status.attach_state &&
                       !st.status.sleep_flag;
    assign timer_clear = bus.bus_activity || bus.bus_reset;

    idle_timer #(
        .LIMIT(IDLE_CYCLES)
    ) u_idle_timer (
        .core_clk(core_clk),
        .reset(reset),
        .run(timer_run),
        .clear(timer_clear),
        .expired(idle_expired)
    );

    wakeup_timer #(
        .LENGTH(WAKE_CYCLES)
    ) u_wakeup_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(st.wake_start),
        .drive(remote_wakeup)
    );

    ////////////////////////////////////////////////////////////////////////
    // Attach and sleep values for the next cycle

    // Power loss overrides a same-cycle attach write
    always_comb begin
        next_attach = st.status.attach_state;
        if (status_write) begin
            next_attach = cmd.wr_data[`STAT_ATTACH_BIT];
        end
        if (vbus_lost) begin
            next_attach = 1'b0;
        end
    end

    // Activity beats idle expiry, so a late edge never leaves it asleep
    always_comb begin
        next_sleep = st.status.sleep_flag;
        if (idle_expired || detach_event) begin
            next_sleep = 1'b1;
        end
        if (bus.bus_activity || reset_rise) begin
            next_sleep = 1'b0;
        end
        // sleep write ignored
        // Writes to bit 2 never load the flag; only a wakeup is ordered
    end

    assign sleep_toggle = next_sleep != st.status.sleep_flag;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.rdata_valid = 1'b0;
        next_st.wake_start = 1'b0;
        next_st.action = '0;
        next_st.vbus_q = bus.vbus_present;
        next_st.reset_q = bus.bus_reset;

        // Any other command ends a pending data phase; a repeated status command keeps it armed
        unique case (st.phase)
            usb_status_pkg::PHASE_IDLE: begin
                if (cmd.cmd_strobe &&
                    cmd.cmd_code == `CMD_DEVICE_STATUS) begin
                    next_st.phase = usb_status_pkg::PHASE_ARMED;
                end
            end
            usb_status_pkg::PHASE_ARMED: begin
                if (cmd.cmd_strobe) begin
                    if (cmd.cmd_code != `CMD_DEVICE_STATUS) begin
                        next_st.phase = usb_status_pkg::PHASE_IDLE;
                    end
                end else if (status_write || status_read) begin
                    next_st.phase = usb_status_pkg::PHASE_IDLE;
                end
            end
            // Two of the four phase codes are unused
            default: begin
                next_st.phase = usb_status_pkg::PHASE_IDLE;
            end
        endcase

        next_st.status.attach_state = next_attach;
        next_st.status.sleep_flag = next_sleep;
        next_st.status.reserved = 3'b000;

        // Snapshot shows flags before this read clears them
        if (status_read) begin
            next_st.rdata = st.status;
            next_st.rdata[7:5] = 3'b000;
            next_st.rdata_valid = 1'b1;
        end

        if (status_read) begin
            next_st.status.attach_change_flag = 1'b0;
        end
        if (vbus_lost) begin
            next_st.status.attach_change_flag = 1'b1;
        end

        if (status_read) begin
            next_st.status.sleep_change_flag = 1'b0;
        end
        if (sleep_toggle) begin
            next_st.status.sleep_change_flag = 1'b1;
        end

        // bus reset flag clear on read
        if (status_read) begin
            next_st.status.bus_reset_flag = 1'b0;
        end
        if (reset_rise) begin
            next_st.status.bus_reset_flag = 1'b1;
        end

        if (status_read) begin
            next_st.irq = 1'b0;
        end
        if (vbus_lost || sleep_toggle || reset_rise) begin
            next_st.irq = 1'b1;
        end

        // Wakeup needs the flag as it stood before this write
        // no action otherwise
        if (status_write && st.status.sleep_flag &&
            st.status.attach_state &&
            !cmd.wr_data[`STAT_SLEEP_BIT]) begin
            next_st.wake_start = 1'b1;
        end

        // Default-state orders fire once, on the reset edge
        if (reset_rise) begin
            next_st.action.unconfigure = 1'b1;
            next_st.action.address_zero = 1'b1;
            next_st.action.stall_control = 1'b1;
            next_st.action.unrealize = 1'b1;
            next_st.action.toggle_reset = 1'b1;
            next_st.action.flush_buffers = 1'b1;
        end
        next_st.action.ep_irq_clear = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Power taken as absent at reset, so no false loss is seen
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st.phase <= usb_status_pkg::PHASE_IDLE;
            st.status <= `STAT_RESET_VALUE;
            st.irq <= 1'b0;
            st.rdata <= 8'h00;
            st.rdata_valid <= 1'b0;
            st.vbus_q <= 1'b0;
            st.reset_q <= 1'b0;
            st.wake_start <= 1'b0;
            st.action <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data = st.rdata;
    assign rd_valid = st.rdata_valid;
    assign status_event_irq = st.irq;
    assign default_action = st.action;

    assign pullup_enable_n = !st.status.attach_state;

    // Control pipe stays realized through a bus reset
    // endpoint mask
    assign unrealize_mask = {NUM_EP{st.action.unrealize}} & ~CTRL_MASK;

    assign toggle_reset_mask = {NUM_EP{st.action.toggle_reset}};

endmodule

//--- sim/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
    input wire logic core_clk,
    output usb_status_pkg::bus_events_t bus
);

    // Powered bus with traffic running
    initial begin
        bus = 3'b110;
    end

    ////////////////////////////////////////////////////////////////////
    // traffic on or off
    task set_activity(input logic a);
        @(negedge core_clk);
        bus.bus_activity = a;
    endtask

    task pulse_reset();
        @(negedge core_clk);
        bus.bus_reset = 1'b1;
        @(negedge core_clk);
        bus.bus_reset = 1'b0;
    endtask

    // power gone, so traffic stops too
    task power_off();
        @(negedge core_clk);
        bus.vbus_present = 1'b0;
        bus.bus_activity = 1'b0;
    endtask

endmodule

//--- sim/usb_device_status_flags_assertions.sv
`timescale 1ns/1ps
module usb_device_status_flags_assertions #(
    parameter int IDLE_CYCLES = 120000,
    parameter int WAKE_CYCLES = 80000,
    parameter int NUM_EP = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire usb_status_pkg::cmd_port_t cmd,
    input wire usb_status_pkg::bus_events_t bus,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic pullup_enable_n,
    input wire logic status_event_irq,
    input wire logic remote_wakeup,
    input wire usb_status_pkg::default_action_t default_action,
    input wire logic [NUM_EP-1:0] unrealize_mask,
    input wire logic [NUM_EP-1:0] toggle_reset_mask
);
    logic armed;
    logic rd_go;
    logic wr_go;
    int wake_run;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Track the data phase opened by the status command
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            armed <= 1'b0;
        end else if (cmd.cmd_strobe) begin
            armed <= cmd.cmd_code == 8'hfe;
        end else if (cmd.wr_strobe || cmd.rd_strobe) begin
            armed <= 1'b0;
        end
    end

    // Length of the current resume drive, in cycles
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wake_run <= 0;
        end else if (remote_wakeup) begin
            wake_run <= wake_run + 1;
        end else begin
            wake_run <= 0;
        end
    end

    // Write wins over read in the same cycle
    assign wr_go = armed && !cmd.cmd_strobe && cmd.wr_strobe;
    assign rd_go = armed && !cmd.cmd_strobe && !cmd.wr_strobe && cmd.rd_strobe;

    sequence s_read_answer;
        ##1 (rd_valid && rd_data[7:5] == 3'h0) ##1 !rd_valid;
    endsequence

    sequence s_default_pulse;
        ##1 (status_event_irq && default_action.unconfigure
            && default_action.address_zero && default_action.stall_control);
    endsequence

    ////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (rd_go |-> s_read_answer)
        else $error("status read answer wrong");
    a_reset_event: assert property (
        $rose(bus.bus_reset) |-> s_default_pulse)
        else $error("bus reset without irq or default order");
    a_action_masks: assert property (default_action.unrealize |->
        (unrealize_mask == {{(NUM_EP-2){1'b1}}, 2'b00} && &toggle_reset_mask)
        ##1 !default_action.unrealize)
        else $error("endpoint masks or pulse length wrong");
    a_ep_irq_kept: assert property (!default_action.ep_irq_clear)
        else $error("endpoint interrupt status cleared");
    a_irq_holds: assert property (
        status_event_irq && !rd_go |=> status_event_irq)
        else $error("status irq dropped without read");
    a_attach_write: assert property (wr_go |=>
        pullup_enable_n == !$past(cmd.wr_data[0]))
        else $error("pull-up not following attach bit");
    a_power_loss: assert property ($fell(bus.vbus_present) &&
        !pullup_enable_n && !wr_go |=> pullup_enable_n && status_event_irq)
        else $error("power loss not handled");
    a_wake_cause: assert property ($rose(remote_wakeup) |->
        $past(wr_go, 2) && !$past(cmd.wr_data[2], 2))
        else $error("remote wakeup without a sleep write");
    a_wake_length: assert property (
        $fell(remote_wakeup) |-> wake_run == WAKE_CYCLES)
        else $error("remote wakeup length wrong");
endmodule

// Hooked to every instance of the flag block
bind usb_device_status_flags usb_device_status_flags_assertions #(
    .IDLE_CYCLES(IDLE_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES),
    .NUM_EP(NUM_EP)
) i_chk (.core_clk(core_clk), .reset(reset), .cmd(cmd), .bus(bus),
    .rd_data(rd_data), .rd_valid(rd_valid), .pullup_enable_n(pullup_enable_n),
    .status_event_irq(status_event_irq), .remote_wakeup(remote_wakeup),
    .default_action(default_action), .unrealize_mask(unrealize_mask),
    .toggle_reset_mask(toggle_reset_mask));

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    // Short counts keep the idle wait brief
    localparam int IDLE = 20;
    localparam int WAKE = 8;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    usb_status_pkg::cmd_port_t cmd = '0;
    usb_status_pkg::bus_events_t bus_ev;
    logic [7:0] rd_data;
    logic rd_valid;
    logic pullup_enable_n;
    logic status_event_irq;
    logic remote_wakeup;
    usb_status_pkg::default_action_t default_action;
    logic [31:0] unrealize_mask;
    logic [31:0] toggle_reset_mask;
    int mismatches = 0;
    int comparisons = 0;
    int n;

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    usb_device_status_flags #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE),
        .NUM_EP(32)) i_dut (.core_clk(core_clk), .reset(reset), .cmd(cmd),
        .bus(bus_ev), .rd_data(rd_data), .rd_valid(rd_valid),
        .pullup_enable_n(pullup_enable_n), .status_event_irq(status_event_irq),
        .remote_wakeup(remote_wakeup), .default_action(default_action),
        .unrealize_mask(unrealize_mask), .toggle_reset_mask(toggle_reset_mask));

    usb_host_model i_host (.core_clk(core_clk), .bus(bus_ev));

    ////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Command byte; only the status code leaves the port armed
    task issue_cmd(input logic [7:0] code);
        @(negedge core_clk);
        cmd.cmd_strobe = 1'b1;
        cmd.cmd_code = code;
        @(negedge core_clk);
        cmd.cmd_strobe = 1'b0;
    endtask

    task wr(input logic [7:0] d);
        issue_cmd(8'hfe);
        cmd.wr_strobe = 1'b1;
        cmd.wr_data = d;
        @(negedge core_clk);
        cmd.wr_strobe = 1'b0;
    endtask

    // Answer is due one edge after the read strobe
    task rdchk(input logic [7:0] exp);
        issue_cmd(8'hfe);
        cmd.rd_strobe = 1'b1;
        @(negedge core_clk);
        cmd.rd_strobe = 1'b0;
        chk("rd_valid", {7'h0, rd_valid}, 8'h01);
        chk("status", rd_data, exp);
    endtask

    task wake_idle();
        repeat (4) @(negedge core_clk);
        chk("wakeup", {7'h0, remote_wakeup}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence; bits 7:5 always written as zero
    initial begin
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        chk("pullup", {7'h0, pullup_enable_n}, 8'h01);
        rdchk(8'h00);
        wr(8'h01);
        chk("pullup", {7'h0, pullup_enable_n}, 8'h00);
        rdchk(8'h01);
        // A data byte after another command must not detach
        issue_cmd(8'hf3);
        cmd.wr_strobe = 1'b1;
        cmd.wr_data = 8'h00;
        @(negedge core_clk);
        cmd.wr_strobe = 1'b0;
        chk("pullup", {7'h0, pullup_enable_n}, 8'h00);
        wr(8'h01);
        wake_idle();
        i_host.set_activity(1'b0);
        repeat (IDLE) @(negedge core_clk);
        chk("irq", {7'h0, status_event_irq}, 8'h00);
        repeat (5) @(negedge core_clk);
        chk("irq", {7'h0, status_event_irq}, 8'h01);
        rdchk(8'h0d);
        rdchk(8'h05);
        chk("irq", {7'h0, status_event_irq}, 8'h00);
        wr(8'h05);
        wake_idle();
        wr(8'h01);
        for (int i = 0; i < 4 && remote_wakeup !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        n = 0;
        while (remote_wakeup === 1'b1 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        chk("wake length", 8'(n), 8'(WAKE));
        rdchk(8'h05);
        i_host.set_activity(1'b1);
        repeat (2) @(negedge core_clk);
        chk("irq", {7'h0, status_event_irq}, 8'h01);
        rdchk(8'h09);
        i_host.pulse_reset();
        chk("action", {1'b0, default_action}, 8'h7e);
        chk("unrealize", unrealize_mask[7:0], 8'hfc);
        chk("toggles", toggle_reset_mask[7:0], 8'hff);
        chk("irq", {7'h0, status_event_irq}, 8'h01);
        rdchk(8'h11);
        rdchk(8'h01);
        // Reset lands on the edge that takes the read
        fork
            rdchk(8'h01);
            begin
                @(negedge core_clk);
                i_host.pulse_reset();
            end
        join
        rdchk(8'h11);
        i_host.power_off();
        repeat (2) @(negedge core_clk);
        chk("pullup", {7'h0, pullup_enable_n}, 8'h01);
        chk("irq", {7'h0, status_event_irq}, 8'h01);
        rdchk(8'h0e);
        rdchk(8'h04);
        wr(8'h00);
        wake_idle();
        rdchk(8'h04);
        final_report();
    end

    // Whole run is under two hundred cycles; cut a hang well past that
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        final_report();
    end
endmodule
